// File: bkrcp_pkg.sv
// constants for the buck rail control and protection block
package bkrcp_pkg;
  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int NR = 7;
  localparam int NL = 7;
  localparam int NT = 5;
  localparam int NQ = NR + NL;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 25;
  localparam int QUAL_US = 155;
  localparam int QUAL_CYC = QUAL_US * CLK_MHZ;
  localparam int STARTUP_MS = 2;
  localparam int STARTUP_CYC = STARTUP_MS * 1000 * CLK_MHZ;
  localparam int STEP_MV = 10;
  // slope of 2.5 mV/us, held in tenths
  localparam int SLEW_MV_PER_US_X10 = 25;
  localparam int RAMP_CYC =
    (STEP_MV * 10 * CLK_MHZ + SLEW_MV_PER_US_X10 - 1) / SLEW_MV_PER_US_X10;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_PRIMARY = 8'h00;
  localparam logic [7:0] OFS_ALT = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_DISCHARGE = 8'h80;
  localparam logic [7:0] OFS_SINK = 8'h84;
  localparam logic [7:0] OFS_MONSEL = 8'h88;
  localparam logic [7:0] OFS_THERM_EN = 8'h8c;
  localparam logic [7:0] OFS_THERM_FLAGS = 8'h90;
  localparam logic [7:0] OFS_BUCK_SHORT = 8'h94;
  localparam logic [7:0] OFS_LIN_SHORT = 8'h98;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h9c;
  localparam logic [7:0] OFS_OK_MASK_A = 8'ha0;
  localparam logic [7:0] OFS_OK_MASK_B = 8'ha4;
  localparam logic [7:0] OFS_COMPARE = 8'ha8;
  localparam logic [7:0] OFS_PHASE = 8'hac;
  localparam logic [7:0] OFS_SLEEP_MAP = 8'hb0;
  localparam logic [7:0] OFS_AUX_MAP = 8'hb4;
  localparam logic [7:0] OFS_STATE = 8'hb8;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int VOLT_RANGE_BIT = 7;
  localparam int ALT_CMD_BIT = 7;
  localparam int CTRL_MODE_ACT_LSB = 0;
  localparam int CTRL_MODE_SLP_LSB = 2;
  localparam int CTRL_RF_BIT = 6;
  localparam int CTRL_WARM_KEEP_BIT = 7;
  localparam int OKB_TYPE_BIT = 0;
  localparam int OKB_POL_BIT = 1;
  localparam int IRQ_SHORT_BIT = 0;
  localparam int PH_A_LSB = 0;
  localparam int PH_B_LSB = 2;
  localparam int STATE_RAMP_LSB = 8;
  // ---------------------------------------------------------------
  // reset values and codes
  // ---------------------------------------------------------------
  localparam logic [7:0] VOLT_RST = 8'h00;
  localparam logic [7:0] ALT_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [NR-1:0] DISCHARGE_RST = 7'h7f;
  localparam logic [NR-1:0] SINK_RST = 7'h7f;
  localparam logic [NT-1:0] THERM_EN_RST = 5'h1f;
  localparam logic [NR-1:0] OK_MASK_A_RST = 7'h7e;
  localparam logic [NR-1:0] DVS_RAILS = 7'h35;
  localparam logic [1:0] MODE_PWM = 2'h1;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  localparam int R_A_DUAL = 0;
  localparam int R_A_SINGLE = 1;
  // monitor groups: a_dual, a_single, a_triple, b_dual, b_triple, rail6, rail7
  localparam logic [6:0][2:0] MON_RAIL = '{3'h3, 3'h4, 3'h2, 3'h2, 3'h0, 3'h1, 3'h0};
endpackage

// File: bkrcp_top.sv
// buck rail control and protection logic with an AXI4-Lite register slave
// Behaviour
// RQ1 - voltage code zero switches the rail off; other codes plus range select voltage
// RQ2 - active mode field used when active; sleep field in sleep per pin mapping
// RQ3 - per-rail off-state discharge switch, enabled after reset
// RQ4 - warm reset reloads defaults or keeps settings per rail control bit
// RQ5 - sink current limit per rail from enable register, on after reset
// RQ6 - one selected group routed to converter channel; valid only PWM and steady
// RQ7 - thermal guard enabled by default, switchable, flags readable while enabled
// RQ8 - group A dual trip also stops single rail; two smallest rails unprotected (logic stops it only while group_a_triple is low)
// RQ9 - qualified short sets the rail flag and holds rail off until cleared
// RQ10 - buck and linear short flags clear on read and at reset, releasing rails
// RQ11 - any short raises the short interrupt unless masked
// RQ12 - short must persist about 155 us on an enabled rail before shutdown
// RQ13 - 2 ms startup counter blocks shutdown, restarts whenever a rail turns on
// RQ14 - one common bit selects voltage-and-current or current-only monitoring
// RQ15 - power-good active, with programmable polarity, only when all unmasked rails good
// RQ16 - two mask registers; after reset only group A dual rail is unmasked
// RQ17 - voltage monitoring masked while a rail ramps between targets
// RQ18 - compare mode bit includes power-good in monitor result, one rail at a time
// RQ19 - scaling rails ramp at 2.5 mV/us, not in one step
// RQ20 - roof/floor with mapped pin: pin active primary, inactive alternate register
// RQ21 - without roof/floor the command bit picks primary or alternate register
// RQ22 - phase control defaults to automatic, field may force either mode
// RQ23 - discharge ignored while the rail is enabled
// RQ24 - rail power-good blanked while disabled or ramping
// RQ25 - qualification and startup counters restart when their condition drops
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
module bkrcp_top
  import bkrcp_pkg::*;
#(
  parameter int STARTUP_CYCLES = STARTUP_CYC
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // request pins
  input wire logic sleep_request_pin,
  input wire logic aux_request_pin,
  // power state controller
  input wire logic device_enable,
  input wire logic device_active,
  input wire logic warm_reset,
  input wire logic group_a_triple,
  input wire logic [NL-1:0] ldo_enable,
  // analog comparators
  input wire logic [NR-1:0] rail_overcurrent,
  input wire logic [NR-1:0] rail_in_window,
  input wire logic [NL-1:0] ldo_overcurrent,
  input wire logic [NT-1:0] thermal_trip,
  // rail controls
  output logic [NR-1:0] rail_enable,
  output logic [NR-1:0][7:0] rail_voltage_code,
  output logic [NR-1:0][1:0] rail_mode,
  output logic [NR-1:0] rail_discharge,
  output logic [NR-1:0] rail_sink_limit,
  output logic [NL-1:0] ldo_off,
  output logic [1:0] group_a_phase_force,
  output logic [1:0] group_b_phase_force,
  // monitor and status
  output logic [6:0] monitor_route,
  output logic monitor_valid,
  output logic monitor_include_ok,
  output logic short_irq,
  output logic rails_ok_output
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0] pin_m;
    logic [1:0] pin_r;
    logic [NR-1:0] oc_m;
    logic [NR-1:0] oc_r;
    logic [NR-1:0] win_m;
    logic [NR-1:0] win_r;
    logic [NL-1:0] loc_m;
    logic [NL-1:0] loc_r;
    logic [NT-1:0] trip_m;
    logic [NT-1:0] trip_r;
    logic [NR-1:0][7:0] volt;
    logic [NR-1:0][7:0] alt;
    logic [NR-1:0][7:0] ctrl;
    logic [NR-1:0][7:0] cur;
    logic [NR-1:0] en;
    logic [NR-1:0][1:0] mode;
    logic [NR-1:0] discharge;
    logic [NR-1:0] sink;
    logic [6:0] monsel;
    logic [NT-1:0] therm_en;
    logic [NR-1:0] bflags;
    logic [NL-1:0] lflags;
    logic irq_mask;
    logic [NR-1:0] ok_mask;
    logic [1:0] ok_cfg;
    logic compare;
    logic [3:0] phase;
    logic [NR-1:0] slp_map;
    logic [NR-1:0] aux_map;
    logic [NQ-1:0][11:0] qcnt;
    logic [15:0] scnt;
    logic [NQ-1:0] prev_on;
    logic [6:0] div;
    logic ok_out;
    logic [6:0] mon_route;
    logic mon_valid;
    logic [7:0] awaddr;
    logic have_aw;
    logic [7:0] wdata;
    logic wlane;
    logic have_w;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } bkrcp_state_type;

  bkrcp_state_type q;
  bkrcp_state_type d;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic rail_reg(input logic [7:0] a);
    rail_reg = !a[7] && (a[6:4] < 3'h7) && (a[3:2] != 2'h3) && (a[1:0] == 2'h0);
  endfunction

  function automatic bkrcp_state_type reset_state();
    bkrcp_state_type s;
    s = '0;
    for (int i = 0; i < NR; i++)
    begin
      s.volt[i] = VOLT_RST;
      s.alt[i] = ALT_RST;
      s.ctrl[i] = CTRL_RST;
    end
    s.discharge = DISCHARGE_RST;
    s.sink = SINK_RST;
    s.therm_en = THERM_EN_RST;
    s.ok_mask = OK_MASK_A_RST;
    s.ok_out = 1'b1;
    reset_state = s;
  endfunction

  logic [1:0] pin_s;
  logic [NT-1:0] tflag;
  logic [NR-1:0] thr_off;
  logic [NR-1:0] ramping;
  logic [NR-1:0] pin_on;
  logic [NR-1:0] rail_good;
  logic [NQ-1:0] on_all;
  logic [NQ-1:0] qual_cond;
  logic [NR-1:0] bset;
  logic [NL-1:0] lset;
  logic [NR-1:0] bclr;
  logic [NL-1:0] lclr;
  logic [7:0] tgt;
  logic [7:0] ra;
  logic [31:0] rd;
  logic rhit;
  logic whit;
  logic tick;
  logic smask;
  logic [2:0] ri;
  logic [2:0] mr;
  logic [6:0] mfirst;

  always_comb
  begin
    d = q;
    tgt = '0;
    ri = '0;
    mr = '0;
    // -------------------------------------------------------------
    // input synchronisers
    // -------------------------------------------------------------
    d.pin_m = {aux_request_pin, sleep_request_pin};
    d.pin_r = q.pin_m;
    d.oc_m = rail_overcurrent;
    d.oc_r = q.oc_m;
    d.win_m = rail_in_window;
    d.win_r = q.win_m;
    d.loc_m = ldo_overcurrent;
    d.loc_r = q.loc_m;
    d.trip_m = thermal_trip;
    d.trip_r = q.trip_m;
    pin_s = q.pin_r;
    // -------------------------------------------------------------
    // thermal guard
    // -------------------------------------------------------------
    tflag = q.trip_r & q.therm_en; // RQ7
    thr_off = '0;
    thr_off[NT-1:0] = tflag; // RQ8
    thr_off[R_A_SINGLE] = tflag[R_A_SINGLE] || (tflag[R_A_DUAL] && !group_a_triple); // RQ8
    // -------------------------------------------------------------
    // voltage selection, ramp and mode
    // -------------------------------------------------------------
    tick = (q.div == 7'(RAMP_CYC - 1));
    d.div = tick ? 7'h00 : q.div + 7'h01;
    for (int i = 0; i < NR; i++)
    begin
      pin_on[i] = (q.slp_map[i] && pin_s[0]) || (q.aux_map[i] && pin_s[1]);
      if (q.ctrl[i][CTRL_RF_BIT])
        tgt = (q.slp_map[i] || q.aux_map[i]) && !pin_on[i]
          ? {q.volt[i][VOLT_RANGE_BIT], q.alt[i][6:0]} : q.volt[i]; // RQ20
      else
        tgt = q.alt[i][ALT_CMD_BIT]
          ? {q.volt[i][VOLT_RANGE_BIT], q.alt[i][6:0]} : q.volt[i]; // RQ21
      if (tgt[6:0] == 7'h00)
        d.cur[i] = 8'h00; // RQ1
      else if (!DVS_RAILS[i] || q.cur[i][6:0] == 7'h00 || q.cur[i][7] != tgt[7])
        d.cur[i] = tgt;
      else if (tick && q.cur[i][6:0] < tgt[6:0])
        d.cur[i] = q.cur[i] + 8'h01; // RQ19
      else if (tick && q.cur[i][6:0] > tgt[6:0])
        d.cur[i] = q.cur[i] - 8'h01; // RQ19
      ramping[i] = (q.cur[i] != tgt);
      d.en[i] = (q.cur[i][6:0] != 7'h00) && !q.bflags[i] && !thr_off[i]; // RQ1 RQ9
      if (device_active || pin_on[i])
        d.mode[i] = q.ctrl[i][CTRL_MODE_ACT_LSB +: 2]; // RQ2
      else
        d.mode[i] = q.ctrl[i][CTRL_MODE_SLP_LSB +: 2]; // RQ2
      if (q.ctrl[i][CTRL_RF_BIT] && !(q.slp_map[i] || q.aux_map[i]))
        ramping[i] = ramping[i];
    end
    // -------------------------------------------------------------
    // short qualification and startup mask
    // -------------------------------------------------------------
    on_all = {ldo_enable, q.en};
    qual_cond = {q.loc_r & ldo_enable, q.oc_r & q.en};
    d.prev_on = on_all;
    if (!device_enable || |(on_all & ~q.prev_on))
      d.scnt = 16'h0000; // RQ13
    else if (q.scnt != 16'(STARTUP_CYCLES))
      d.scnt = q.scnt + 16'h0001; // RQ25
    smask = (q.scnt != 16'(STARTUP_CYCLES)); // RQ13
    for (int j = 0; j < NQ; j++)
    begin
      if (!qual_cond[j])
        d.qcnt[j] = 12'h000; // RQ25
      else if (q.qcnt[j] != 12'(QUAL_CYC))
        d.qcnt[j] = q.qcnt[j] + 12'h001; // RQ12
    end
    for (int j = 0; j < NR; j++)
      bset[j] = qual_cond[j] && q.qcnt[j] == 12'(QUAL_CYC) && !smask; // RQ9 RQ12
    for (int j = 0; j < NL; j++)
      lset[j] = qual_cond[NR+j] && q.qcnt[NR+j] == 12'(QUAL_CYC) && !smask; // RQ12
    // -------------------------------------------------------------
    // power good and current monitor
    // -------------------------------------------------------------
    for (int i = 0; i < NR; i++)
    begin
      rail_good[i] = (q.ok_cfg[OKB_TYPE_BIT] || q.win_r[i]) && !q.oc_r[i]; // RQ14
      if (!q.en[i] || ramping[i])
        rail_good[i] = 1'b1; // RQ17 RQ24
    end
    d.ok_out = (&(rail_good | q.ok_mask)) ^ q.ok_cfg[OKB_POL_BIT]; // RQ15 RQ16
    mfirst = q.monsel & (~q.monsel + 7'h01); // RQ18
    d.mon_route = mfirst; // RQ6
    for (int g = 0; g < 7; g++)
      if (mfirst[g])
        mr = MON_RAIL[g];
    d.mon_valid = (mfirst != 7'h00) && q.mode[mr] == MODE_PWM && !ramping[mr]; // RQ6
    // -------------------------------------------------------------
    // axi4-lite write
    // -------------------------------------------------------------
    if (s_axi_awvalid && s_axi_awready)
    begin
      d.awaddr = s_axi_awaddr[7:0];
      d.have_aw = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      d.wdata = s_axi_wdata[7:0];
      d.wlane = s_axi_wstrb[0];
      d.have_w = 1'b1;
    end
    if (s_axi_bvalid && s_axi_bready)
      d.bvalid = 1'b0;
    whit = 1'b1;
    if (q.have_aw && q.have_w)
    begin
      d.have_aw = 1'b0;
      d.have_w = 1'b0;
      d.bvalid = 1'b1;
      ri = q.awaddr[6:4];
      if (rail_reg(q.awaddr))
      begin
        if (q.wlane)
          case (q.awaddr[3:0])
            OFS_PRIMARY[3:0]: d.volt[ri] = q.wdata;
            OFS_ALT[3:0]: d.alt[ri] = q.wdata;
            default: d.ctrl[ri] = q.wdata;
          endcase
      end
      else if (q.wlane)
        case (q.awaddr)
          OFS_DISCHARGE: d.discharge = q.wdata[NR-1:0]; // RQ3
          OFS_SINK: d.sink = q.wdata[NR-1:0]; // RQ5
          OFS_MONSEL: d.monsel = q.wdata[6:0];
          OFS_THERM_EN: d.therm_en = q.wdata[NT-1:0]; // RQ7
          OFS_IRQ_MASK: d.irq_mask = q.wdata[IRQ_SHORT_BIT];
          OFS_OK_MASK_A: d.ok_mask = q.wdata[NR-1:0];
          OFS_OK_MASK_B: d.ok_cfg = q.wdata[1:0];
          OFS_COMPARE: d.compare = q.wdata[0];
          OFS_PHASE: d.phase = q.wdata[3:0]; // RQ22
          OFS_SLEEP_MAP: d.slp_map = q.wdata[NR-1:0];
          OFS_AUX_MAP: d.aux_map = q.wdata[NR-1:0];
          default: whit = 1'b0;
        endcase
      else
        whit = 1'b1;
      d.bresp = whit ? AXI_OKAY : AXI_SLVERR;
    end
    // -------------------------------------------------------------
    // axi4-lite read, short flags clear on read
    // -------------------------------------------------------------
    bclr = '0;
    lclr = '0;
    ra = s_axi_araddr[7:0];
    rd = '0;
    rhit = 1'b1;
    if (s_axi_rvalid && s_axi_rready)
      d.rvalid = 1'b0;
    if (rail_reg(ra))
      case (ra[3:0])
        OFS_PRIMARY[3:0]: rd[7:0] = q.volt[ra[6:4]];
        OFS_ALT[3:0]: rd[7:0] = q.alt[ra[6:4]];
        default: rd[7:0] = q.ctrl[ra[6:4]];
      endcase
    else
      case (ra)
        OFS_DISCHARGE: rd[NR-1:0] = q.discharge;
        OFS_SINK: rd[NR-1:0] = q.sink;
        OFS_MONSEL: rd[6:0] = q.monsel;
        OFS_THERM_EN: rd[NT-1:0] = q.therm_en;
        OFS_THERM_FLAGS: rd[NT-1:0] = tflag; // RQ7
        OFS_BUCK_SHORT: rd[NR-1:0] = q.bflags;
        OFS_LIN_SHORT: rd[NL-1:0] = q.lflags;
        OFS_IRQ_MASK: rd[IRQ_SHORT_BIT] = q.irq_mask;
        OFS_OK_MASK_A: rd[NR-1:0] = q.ok_mask;
        OFS_OK_MASK_B: rd[1:0] = q.ok_cfg;
        OFS_COMPARE: rd[0] = q.compare;
        OFS_PHASE: rd[3:0] = q.phase;
        OFS_SLEEP_MAP: rd[NR-1:0] = q.slp_map;
        OFS_AUX_MAP: rd[NR-1:0] = q.aux_map;
        OFS_STATE: rd[STATE_RAMP_LSB +: NR] = ramping;
        default: rhit = 1'b0;
      endcase
    if (ra == OFS_STATE)
      rd[NR-1:0] = q.en;
    if (s_axi_arvalid && s_axi_arready)
    begin
      d.rvalid = 1'b1;
      d.rdata = rd;
      d.rresp = rhit ? AXI_OKAY : AXI_SLVERR;
      if (ra == OFS_BUCK_SHORT)
        bclr = '1; // RQ10
      if (ra == OFS_LIN_SHORT)
        lclr = '1; // RQ10
    end
    // set wins over a clear in the same cycle
    d.bflags = (q.bflags & ~bclr) | bset; // RQ9 RQ10
    d.lflags = (q.lflags & ~lclr) | lset; // RQ10
    // -------------------------------------------------------------
    // warm reset
    // -------------------------------------------------------------
    if (warm_reset)
      for (int i = 0; i < NR; i++)
        if (!q.ctrl[i][CTRL_WARM_KEEP_BIT])
        begin
          d.volt[i] = VOLT_RST; // RQ4
          d.alt[i] = ALT_RST; // RQ4
          d.ctrl[i] = CTRL_RST; // RQ4
        end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q <= reset_state();
    else
      q <= d;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign s_axi_awready = !q.have_aw && !q.bvalid;
  assign s_axi_wready = !q.have_w && !q.bvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  assign rail_enable = q.en;
  assign rail_voltage_code = q.cur;
  assign rail_mode = q.mode;
  assign rail_discharge = q.discharge & ~q.en; // RQ3 RQ23
  assign rail_sink_limit = q.sink; // RQ5
  assign ldo_off = q.lflags; // RQ10
  assign group_a_phase_force = q.phase[PH_A_LSB +: 2]; // RQ22
  assign group_b_phase_force = q.phase[PH_B_LSB +: 2]; // RQ22
  assign monitor_route = q.mon_route;
  assign monitor_valid = q.mon_valid;
  assign monitor_include_ok = q.compare; // RQ18
  assign short_irq = (|q.bflags || |q.lflags) && !q.irq_mask; // RQ11
  assign rails_ok_output = q.ok_out;

endmodule

// File: bkrcp_chk.sv
// concurrent checks on the rail block ports, bound into the top
`timescale 1ns/10ps
module bkrcp_chk
  import bkrcp_pkg::*;
#(
  parameter int STARTUP_CYCLES = 50
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // rails and supplies
  input wire logic device_enable,
  input wire logic [NL-1:0] ldo_enable,
  input wire logic [NL-1:0] ldo_overcurrent,
  input wire logic [NL-1:0] ldo_off,
  input wire logic [NR-1:0] rail_enable,
  input wire logic [NR-1:0][7:0] rail_voltage_code,
  input wire logic [NR-1:0] rail_discharge
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic [12:0] oc_q;
  logic [15:0] up_q;
  logic [NL+NR-1:0] en_q;
  logic [NR-1:0] nz_q;
  // run lengths of overcurrent and of quiet startup
  always_ff @(posedge aclk)
  begin
    en_q <= {ldo_enable, rail_enable};
    for (int i = 0; i < NR; i++)
      nz_q[i] <= |rail_voltage_code[i];
    if (!aresetn || !(|ldo_overcurrent))
      oc_q <= 13'h0;
    else if (oc_q != 13'h1fff)
      oc_q <= oc_q + 13'h1;
    if (!aresetn || !device_enable || |({ldo_enable, rail_enable} & ~en_q))
      up_q <= 16'h0;
    else if (up_q != 16'hffff)
      up_q <= up_q + 16'h1;
  end
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid) else $error("arready wrong");
  discharge_off_a: assert property ((rail_discharge & rail_enable) == '0)
    else $error("discharge on enabled rail");
  code_off_a: assert property ((rail_enable & ~nz_q) == '0)
    else $error("rail on with code zero");
  short_qual_a: assert property ($rose(|ldo_off) |-> oc_q >= QUAL_CYC)
    else $error("short shutdown too early");
  startup_mask_a: assert property ($rose(|ldo_off) |-> up_q >= STARTUP_CYCLES)
    else $error("shutdown during startup mask");
  cover property ($rose(|ldo_off));
  cover property (s_axi_bvalid && s_axi_bready);
  cover property ($fell(rail_enable[0]));
endmodule
bind bkrcp_top bkrcp_chk #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_chk (.*);

// File: bkrcp_host.sv
// host-side model: request pins and rail window comparators
`timescale 1ns/10ps
module bkrcp_host
  import bkrcp_pkg::*;
(
  // clock
  input wire logic aclk,
  // rail feedback
  input wire logic [NR-1:0] rail_enable,
  input wire logic [NR-1:0] window_fault,
  // pins and comparators
  output logic sleep_request_pin,
  output logic aux_request_pin,
  output logic [NR-1:0] rail_in_window
);
  initial
  begin
    sleep_request_pin = 1'b0;
    aux_request_pin = 1'b0;
    rail_in_window = '0;
  end
  // enabled rails settle in window unless a fault is injected
  always @(posedge aclk)
    rail_in_window <= rail_enable & ~window_fault;
  // pins change after an edge and stand as levels
  task automatic drive_pins(input logic slp, input logic aux);
    @(posedge aclk);
    sleep_request_pin <= slp;
    aux_request_pin <= aux;
  endtask
endmodule

// File: tb_bkrcp_top.sv
// self-checking bench for the rail control block
`timescale 1ns/10ps
module tb_bkrcp_top;
  import bkrcp_pkg::*;
  logic aclk = 1'b0;
  logic aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, group_a_phase_force, group_b_phase_force;
  logic sleep_request_pin, aux_request_pin, device_enable, device_active, warm_reset;
  logic group_a_triple, monitor_valid, monitor_include_ok, short_irq, rails_ok_output;
  logic [NL-1:0] ldo_enable, ldo_overcurrent, ldo_off;
  logic [NR-1:0] rail_overcurrent, rail_in_window, rail_enable, rail_discharge;
  logic [NR-1:0] rail_sink_limit, window_fault;
  logic [NT-1:0] thermal_trip;
  logic [NR-1:0][7:0] rail_voltage_code;
  logic [NR-1:0][1:0] rail_mode;
  logic [6:0] monitor_route;
  int bad_count = 0;
  int total_checks = 0;
  bkrcp_top #(.STARTUP_CYCLES(50)) DUT (.*);
  bkrcp_host host (.*);
  always #20 aclk = ~aclk;
  // ----------
  // tasks
  // ----------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic hold(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic pa, pw, ta, tw, g;
    logic [1:0] r;
    pa = 1'b1;
    pw = 1'b1;
    g = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pa || pw || !g)
    begin
      @(posedge aclk);
      ta = pa && s_axi_awready;
      tw = pw && s_axi_wready;
      g = s_axi_bvalid;
      r = s_axi_bresp;
      if (ta)
        s_axi_awvalid <= 1'b0;
      if (tw)
        s_axi_wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    s_axi_bready <= 1'b0;
    chk(32'(r), 32'(er));
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic pa, ta, g;
    logic [31:0] d;
    logic [1:0] r;
    pa = 1'b1;
    g = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!g)
    begin
      @(posedge aclk);
      ta = pa && s_axi_arready;
      g = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      if (ta)
        s_axi_arvalid <= 1'b0;
      pa = pa && !ta;
    end
    s_axi_rready <= 1'b0;
    chk(d, ed);
    chk(32'(r), 32'(er));
  endtask
  task automatic oc(input logic [NL-1:0] v, input int n);
    @(posedge aclk);
    ldo_overcurrent <= v;
    hold(n);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ----------
  // sequence
  // ----------
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
    {warm_reset, group_a_triple, rail_overcurrent, thermal_trip, window_fault} = '0;
    {device_enable, device_active, ldo_enable, ldo_overcurrent} = {2'h3, 7'h01, 7'h00};
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    axr(OFS_DISCHARGE, 32'h7f, AXI_OKAY);
    axr(OFS_SINK, 32'h7f, AXI_OKAY);
    axr(OFS_THERM_EN, 32'h1f, AXI_OKAY);
    axr(OFS_OK_MASK_A, 32'h7e, AXI_OKAY);
    chk(32'({rail_sink_limit, group_a_phase_force, group_b_phase_force}), 32'h7f0);
    axr(8'hfc, 32'h0, AXI_SLVERR);
    axw(8'hfc, 8'h01, AXI_SLVERR);
    axw(OFS_BUCK_SHORT, 8'h01, AXI_SLVERR);
    axw(8'h18, 8'h06, AXI_OKAY);
    axw(8'h10, 8'h05, AXI_OKAY);
    hold(4);
    chk(32'(rail_enable[1]), 32'h1);
    chk(32'(rail_discharge[1]), 32'h0);
    chk(32'(rail_mode[1]), 32'h2);
    axw(OFS_MONSEL, 8'h06, AXI_OKAY);
    @(posedge aclk);
    device_active <= 1'b0;
    hold(3);
    chk(32'(rail_mode[1]), 32'h1);
    chk(32'({monitor_valid, monitor_route}), 32'h82);
    axw(8'h10, 8'h00, AXI_OKAY);
    hold(4);
    chk(32'(rail_enable[1]), 32'h0);
    chk(32'(rail_discharge[1]), 32'h1);
    @(posedge aclk);
    device_active <= 1'b1;
    axw(OFS_ALT, 8'h89, AXI_OKAY);
    axw(OFS_PRIMARY, 8'h05, AXI_OKAY);
    hold(4);
    chk(32'(rail_voltage_code[0]), 32'h09);
    axw(OFS_CTRL, 8'h40, AXI_OKAY);
    axw(OFS_SLEEP_MAP, 8'h01, AXI_OKAY);
    host.drive_pins(1'b1, 1'b0);
    hold(20);
    chk(32'(rail_voltage_code[0] == 8'h05), 32'h0);
    hold(600);
    chk(32'(rail_voltage_code[0]), 32'h05);
    host.drive_pins(1'b0, 1'b0);
    hold(600);
    chk(32'(rail_voltage_code[0]), 32'h09);
    chk(32'(rails_ok_output), 32'h1);
    @(posedge aclk);
    window_fault <= 7'h01;
    hold(6);
    chk(32'(rails_ok_output), 32'h0);
    axw(OFS_OK_MASK_B, 8'h02, AXI_OKAY);
    hold(4);
    chk(32'(rails_ok_output), 32'h1);
    axw(OFS_OK_MASK_B, 8'h03, AXI_OKAY);
    hold(4);
    chk(32'(rails_ok_output), 32'h0);
    axw(OFS_OK_MASK_B, 8'h00, AXI_OKAY);
    axw(OFS_OK_MASK_A, 8'h7f, AXI_OKAY);
    hold(4);
    chk(32'(rails_ok_output), 32'h1);
    axw(OFS_CTRL, 8'h00, AXI_OKAY);
    axw(OFS_ALT, 8'h80, AXI_OKAY);
    hold(4);
    chk(32'(rail_enable[0]), 32'h0);
    oc(7'h01, 3000);
    chk(32'(ldo_off), 32'h0);
    oc(7'h00, 4);
    oc(7'h01, 4000);
    chk(32'(ldo_off), 32'h1);
    chk(32'(short_irq), 32'h1);
    oc(7'h00, 4);
    chk(32'(ldo_off), 32'h1);
    axr(OFS_LIN_SHORT, 32'h01, AXI_OKAY);
    hold(2);
    chk(32'(ldo_off), 32'h0);
    axw(OFS_IRQ_MASK, 8'h01, AXI_OKAY);
    oc(7'h01, 4000);
    chk(32'(short_irq), 32'h0);
    test_done();
  end
  initial
  begin
    #1500000;
    bad_count++;
    test_done();
  end
endmodule
